// ### nvic_pkg.sv
// nvic_pkg: constants, access encodings and carrier types of the nested interrupt controller
// Functional notes
// RL1 - There are 35 request inputs and each one carries a 3-bit level, giving eight levels.
// RL2 - A privileged access may read and write every register without restriction. Here, writes to the active words have no effect.
// RL3 - When the user pend permission input is high, an unprivileged write to the set-pending words is accepted.
// RL4 - Any other unprivileged access has no effect and answers with a fault.
// RL5 - Every register accepts byte, halfword and word accesses.
// RL6 - The handler starts 12 cycles after acceptance, or 6 cycles when it chains straight from an exit.
// RL7 - Levels may be rewritten at any time, and the active bits record the nesting of handlers.
// RL8 - Only a strictly higher level preempts, and among equal levels the lowest number wins.
package nvic_pkg;
  // =====================================================================
  // sizes
  localparam int NUM_IRQ = 35;
  localparam int PRIO_W  = 3;
  localparam int IDX_W   = 6;
  localparam int CNT_W   = 4;
  // =====================================================================
  // entry timing in core cycles
  localparam logic [CNT_W-1:0] ENTRY_CYCLES = 4'hC;
  localparam logic [CNT_W-1:0] TAIL_CYCLES  = 4'h6;
  // =====================================================================
  // byte offsets on the access port
  localparam logic [7:0] OFS_SET_EN   = 8'h00;
  localparam logic [7:0] OFS_CLR_EN   = 8'h08;
  localparam logic [7:0] OFS_SET_PEND = 8'h10;
  localparam logic [7:0] OFS_CLR_PEND = 8'h18;
  localparam logic [7:0] OFS_ACTIVE   = 8'h20;
  localparam logic [7:0] OFS_PRIO     = 8'h40;
  localparam logic [7:0] OFS_PRIO_END = 8'h63;
  // =====================================================================
  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // level that no real handler can reach, used when nothing is active
  localparam logic [PRIO_W:0] IDLE_LEVEL = 4'h8;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        priv;
    logic [1:0]  size;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } nvic_acc_t;

  typedef logic [NUM_IRQ-1:0][PRIO_W-1:0] nvic_prio_t;
endpackage

// ### nvic_arbiter.sv
// nvic_arbiter: picks the best-ranked source out of a mask
`timescale 1ns/1ps
`default_nettype none
module nvic_arbiter (
  input  wire logic [nvic_pkg::NUM_IRQ-1:0] mask,
  input  wire nvic_pkg::nvic_prio_t         prio,
  output logic                              found,
  output logic [nvic_pkg::IDX_W-1:0]        idx,
  output logic [nvic_pkg::PRIO_W:0]         level
);
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    level = nvic_pkg::IDLE_LEVEL;
    // ascending scan with strict compare keeps the lowest number on ties
    for (int i = 0; i < nvic_pkg::NUM_IRQ; i++)
    begin
      if (mask[i] && ({1'b0, prio[i]} < level)) // [RL8]
      begin
        found = 1'b1;
        idx   = nvic_pkg::IDX_W'(i);
        level = {1'b0, prio[i]};
      end
    end
  end
endmodule // nvic_arbiter
`default_nettype wire

// ### nvic_core.sv
// nvic_core: nested interrupt controller with privilege-checked access port and entry sequencer
`timescale 1ns/1ps
`default_nettype none
module nvic_core (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic                              ce,
  input  wire logic [nvic_pkg::NUM_IRQ-1:0]      irq_req,
  input  wire logic                              cfg_user_pend,
  input  wire nvic_pkg::nvic_acc_t               acc,
  input  wire logic                              core_exit,
  output logic                                   acc_ready,
  output logic                                   acc_fault,
  output logic [31:0]                            acc_rdata,
  output logic                                   handler_start,
  output logic [nvic_pkg::IDX_W-1:0]             handler_vector,
  output logic                                   entry_busy,
  output logic                                   nest_active
);
  // =====================================================================
  // local sizes and steps
  localparam int                         PRIO_WORDS = (nvic_pkg::NUM_IRQ + 3) / 4;
  localparam int                         PAD_W      = 64 - nvic_pkg::NUM_IRQ;
  localparam int                         BYTE_PAD   = 8 - nvic_pkg::PRIO_W;
  localparam int                         LANES      = 4;
  localparam int                         LANE_W     = 8;
  localparam logic [nvic_pkg::CNT_W-1:0] CNT_STEP   = 4'h1;
  localparam logic [5:0]                 PRIO_WORD0 = nvic_pkg::OFS_PRIO[7:2];
  localparam logic [nvic_pkg::NUM_IRQ-1:0] BIT0     = 35'h1;

  typedef enum logic {ST_IDLE, ST_ENTRY} nvic_state_t;

  // =====================================================================
  // state
  logic [nvic_pkg::NUM_IRQ-1:0]   enable;
  logic [nvic_pkg::NUM_IRQ-1:0]   pending;   // [RL1]
  logic [nvic_pkg::NUM_IRQ-1:0]   active;
  logic [nvic_pkg::NUM_IRQ-1:0]   irq_prev;
  logic [nvic_pkg::PRIO_W-1:0]    prio_mem [nvic_pkg::NUM_IRQ];
  nvic_state_t                    state;
  logic [nvic_pkg::CNT_W-1:0]     cnt;
  logic [nvic_pkg::IDX_W-1:0]     entry_idx;

  // =====================================================================
  // access decode
  logic                           take;
  logic                           user_pend_ok;
  logic                           allowed;
  logic                           wr_ok;
  logic [3:0]                     be;
  logic [4:0]                     grp;
  logic [31:0]                    lane_mask;
  logic [31:0]                    wmasked;
  logic [63:0]                    wbits64;
  logic [nvic_pkg::NUM_IRQ-1:0]   wbits;
  logic [63:0]                    en64;
  logic [63:0]                    pend64;
  logic [63:0]                    act64;
  logic [5:0]                     prio_word;
  logic [31:0]                    next_rdata;
  wire  nvic_pkg::nvic_prio_t     prio;
  wire  [PRIO_WORDS*32-1:0]       prio_flat;

  // =====================================================================
  // ranking and entry
  logic [nvic_pkg::NUM_IRQ-1:0]   cand_mask;
  logic                           cand_found;
  logic [nvic_pkg::IDX_W-1:0]     cand_idx;
  logic [nvic_pkg::PRIO_W:0]      cand_level;
  logic [nvic_pkg::IDX_W-1:0]     run_idx;
  logic [nvic_pkg::PRIO_W:0]      run_level;
  logic [nvic_pkg::NUM_IRQ-1:0]   exit_mask;
  logic [nvic_pkg::NUM_IRQ-1:0]   active_left;
  logic [nvic_pkg::NUM_IRQ-1:0]   start_mask;
  logic [nvic_pkg::NUM_IRQ-1:0]   pend_set;
  logic [nvic_pkg::NUM_IRQ-1:0]   pend_clr;
  logic [nvic_pkg::NUM_IRQ-1:0]   next_pend;
  logic [nvic_pkg::NUM_IRQ-1:0]   next_active;
  logic                           accept;
  logic                           start_now;

  // =====================================================================
  // access port: one request taken per answer, never twice
  assign take         = acc.valid && !acc_ready;
  assign grp          = acc.addr[7:3];
  assign user_pend_ok = acc.write && cfg_user_pend
                        && (grp == nvic_pkg::OFS_SET_PEND[7:3]); // [RL3]
  assign allowed      = (acc.priv || user_pend_ok) && (be != 4'h0); // [RL2] [RL4]
  assign wr_ok        = take && allowed && acc.write;

  // lanes follow a 32-bit bus, so a narrow write only touches its own bytes
  always_comb
  begin
    unique case (acc.size)
      nvic_pkg::SZ_BYTE: be = 4'h1 << acc.addr[1:0]; // [RL5]
      nvic_pkg::SZ_HALF: be = acc.addr[1] ? 4'hC : 4'h3; // [RL5]
      nvic_pkg::SZ_WORD: be = 4'hF; // [RL5]
      default:           be = 4'h0;
    endcase
  end

  assign lane_mask = {{LANE_W{be[3]}}, {LANE_W{be[2]}}, {LANE_W{be[1]}}, {LANE_W{be[0]}}};
  assign wmasked   = acc.wdata & lane_mask;
  assign wbits64   = acc.addr[2] ? {wmasked, 32'h0} : {32'h0, wmasked};
  assign wbits     = wbits64[nvic_pkg::NUM_IRQ-1:0];

  // =====================================================================
  // read side
  assign en64      = {{PAD_W{1'h0}}, enable};
  assign pend64    = {{PAD_W{1'h0}}, pending};
  assign act64     = {{PAD_W{1'h0}}, active};
  assign prio_word = acc.addr[7:2] - PRIO_WORD0;
  assign prio_flat[PRIO_WORDS*32-1:nvic_pkg::NUM_IRQ*LANE_W] = '0;

  always_comb
  begin
    next_rdata = '0;
    unique case (grp)
      nvic_pkg::OFS_SET_EN[7:3], nvic_pkg::OFS_CLR_EN[7:3]:
        next_rdata = acc.addr[2] ? en64[63:32] : en64[31:0];
      nvic_pkg::OFS_SET_PEND[7:3], nvic_pkg::OFS_CLR_PEND[7:3]:
        next_rdata = acc.addr[2] ? pend64[63:32] : pend64[31:0];
      nvic_pkg::OFS_ACTIVE[7:3]:
        next_rdata = acc.addr[2] ? act64[63:32] : act64[31:0];
      default:
      begin
        if (acc.addr >= nvic_pkg::OFS_PRIO && acc.addr <= nvic_pkg::OFS_PRIO_END)
          next_rdata = prio_flat[int'(prio_word)*32 +: 32];
      end
    endcase
  end

  // answer stands until the next request is taken
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_ready <= 1'h0;
      acc_fault <= 1'h0;
      acc_rdata <= '0;
    end
    else if (ce)
    begin
      acc_ready <= take;
      if (take)
      begin
        acc_fault <= !allowed; // [RL4]
        acc_rdata <= (allowed && !acc.write) ? next_rdata : '0;
      end
    end
  end

  // =====================================================================
  // level storage, one byte slot per source
  for (genvar i = 0; i < nvic_pkg::NUM_IRQ; i++)
  begin : g_entry
    localparam logic [5:0] WORD = PRIO_WORD0 + 6'(i / LANES);
    localparam int         LANE = i % LANES;

    assign prio[i]                     = prio_mem[i];
    assign prio_flat[i*LANE_W +: LANE_W] = {{BYTE_PAD{1'h0}}, prio_mem[i]};

    // may change while the source is pending; ranking uses the new level at once
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        prio_mem[i] <= '0;
      else if (ce && wr_ok && acc.addr[7:2] == WORD && be[LANE]) // [RL7] [RL5]
        prio_mem[i] <= acc.wdata[LANE*LANE_W +: nvic_pkg::PRIO_W];
    end
  end

  // =====================================================================
  // enables
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      enable <= '0;
    else if (ce && wr_ok)
    begin
      if (grp == nvic_pkg::OFS_SET_EN[7:3])
        enable <= enable | wbits;
      else if (grp == nvic_pkg::OFS_CLR_EN[7:3])
        enable <= enable & ~wbits;
    end
  end

  // =====================================================================
  // pending: a new request edge wins over a clear in the same cycle
  assign pend_set  = (irq_req & ~irq_prev)
                     | ((wr_ok && grp == nvic_pkg::OFS_SET_PEND[7:3]) ? wbits : '0); // [RL3]
  assign pend_clr  = ((wr_ok && grp == nvic_pkg::OFS_CLR_PEND[7:3]) ? wbits : '0)
                     | (accept ? (BIT0 << cand_idx) : '0);
  assign next_pend = (pending & ~pend_clr) | pend_set;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pending  <= '0;
      irq_prev <= '0;
    end
    else if (ce)
    begin
      pending  <= next_pend; // [RL1]
      irq_prev <= irq_req;
    end
  end

  // =====================================================================
  // ranking
  assign cand_mask = pending & enable;

  nvic_arbiter i_nvic_arbiter_cand (
    .mask  (cand_mask),
    .prio  (prio),
    .found (cand_found),
    .idx   (cand_idx),
    .level (cand_level)
  );

  nvic_arbiter i_nvic_arbiter_run (
    .mask  (active),
    .prio  (prio),
    .found (),
    .idx   (run_idx),
    .level ()
  );

  // level left once the exiting handler is gone, so chaining sees it
  assign exit_mask   = core_exit ? (BIT0 << run_idx) : '0;
  assign active_left = active & ~exit_mask;

  nvic_arbiter i_nvic_arbiter_left (
    .mask  (active_left),
    .prio  (prio),
    .found (),
    .idx   (),
    .level (run_level)
  );

  // strictly higher level only; late arrivals wait for the next entry
  assign accept = (state == ST_IDLE) && cand_found && (cand_level < run_level); // [RL8]

  // =====================================================================
  // entry sequencer
  assign start_now = (state == ST_ENTRY) && (cnt == '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state          <= ST_IDLE;
      cnt            <= '0;
      entry_idx      <= '0;
      entry_busy     <= 1'h0;
      handler_start  <= 1'h0;
      handler_vector <= '0;
    end
    else if (ce)
    begin
      handler_start <= 1'h0;
      unique case (state)
        ST_IDLE:
        begin
          if (accept)
          begin
            state      <= ST_ENTRY;
            entry_busy <= 1'h1;
            entry_idx  <= cand_idx;
            // chained entry skips the state restore
            cnt        <= core_exit ? (nvic_pkg::TAIL_CYCLES - CNT_STEP)
                                    : (nvic_pkg::ENTRY_CYCLES - CNT_STEP); // [RL6]
          end
        end
        ST_ENTRY:
        begin
          if (cnt == '0)
          begin
            state          <= ST_IDLE;
            entry_busy     <= 1'h0;
            handler_start  <= 1'h1; // [RL6]
            handler_vector <= entry_idx;
          end
          else
            cnt <= cnt - CNT_STEP;
        end
      endcase
    end
  end

  // =====================================================================
  // nesting record
  assign start_mask  = start_now ? (BIT0 << entry_idx) : '0;
  assign next_active = active_left | start_mask;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      active      <= '0;
      nest_active <= 1'h0;
    end
    else if (ce)
    begin
      active      <= next_active; // [RL7]
      nest_active <= |next_active;
    end
  end
endmodule // nvic_core
`default_nettype wire

// ### nvic_core_model.sv
// core-side model: leaves each handler a few cycles after it starts
`timescale 1ns/1ps
`default_nettype none
module nvic_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hs,
  output logic      core_exit
);
  logic [2:0] dly;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dly <= 3'h0;
    else
      dly <= {dly[1:0], hs};
  end
  assign core_exit = dly[2]; // short handlers stress chaining
endmodule // nvic_core_model
`default_nettype wire

// ### nvic_core_chk.sv
// assertions on the access port and entry timing
`timescale 1ns/1ps
`default_nettype none
module nvic_core_chk (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cfg_user_pend,
  input  wire nvic_pkg::nvic_acc_t acc,
  input  wire logic                acc_ready,
  input  wire logic                acc_fault,
  input  wire logic                handler_start,
  input  wire logic                entry_busy,
  input  wire logic                core_exit,
  input  wire logic                nest_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire done = acc.valid && acc_ready;
  wire okay = acc.size != 2'h3;
  wire pend = acc.write && cfg_user_pend && acc.addr[7:3] == nvic_pkg::OFS_SET_PEND[7:3];
  chk_user_fault: assert property (done && !acc.priv && !pend |-> acc_fault)
    else $error("user access not faulted");
  chk_priv_clean: assert property (done && acc.priv && okay |-> !acc_fault)
    else $error("privileged access faulted");
  chk_pend_clean: assert property (done && pend && okay |-> !acc_fault)
    else $error("user pend faulted");
  chk_entry_len: assert property ($rose(entry_busy) |-> ##[6:12] handler_start)
    else $error("handler start late");
  chk_entry_full: assert property ($rose(entry_busy) && !$past(core_exit) |-> ##12 handler_start)
    else $error("full entry length wrong");
  chk_entry_tail: assert property ($rose(entry_busy) && $past(core_exit) |-> ##6 handler_start)
    else $error("chained entry length wrong");
  chk_nest_flag: assert property (handler_start |-> nest_active)
    else $error("running handler not recorded");
  cover property (done && pend);
  cover property (handler_start);
  cover property (done && !acc.priv && acc_fault);
endmodule // nvic_core_chk
bind nvic_core nvic_core_chk i_nvic_core_chk (.*);
`default_nettype wire

// ### tb_nvic_core.sv
// random bench for the nested interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module tb_nvic_core;
  logic clk = 0, rst_n = 0, pend = 0, ce = 1, ex, rdy, flt, hs, busy, nest;
  logic [5:0]  vec;
  logic [31:0] rd;
  logic [34:0] irq = '0;
  logic [2:0]  tb_prio [35];
  nvic_pkg::nvic_acc_t acc = '0;
  int num_errors = 0, checks_done = 0;
  initial forever #4 clk = ~clk;
  nvic_core i_nvic_core (.clk, .rst_n, .ce, .irq_req(irq), .cfg_user_pend(pend), .acc,
    .core_exit(ex), .acc_ready(rdy), .acc_fault(flt), .acc_rdata(rd), .handler_start(hs),
    .handler_vector(vec), .entry_busy(busy), .nest_active(nest));
  nvic_core_model i_nvic_core_model (.clk, .rst_n, .hs, .core_exit(ex));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    num_errors++;
    $display("CHECK FAILED %0t wait ran out", $time);
    report_and_stop;
  endtask
  // lowest level wins, ties to the lowest number
  function automatic int best(input logic [34:0] m);
    int b;
    b = -1;
    for (int i = 0; i < 35; i++) if (m[i] && (b < 0 || tb_prio[i] < tb_prio[b])) b = i;
    return b;
  endfunction
  function automatic logic [31:0] prio_word(input int w);
    logic [31:0] r;
    r = '0;
    for (int j = 0; j < 4; j++) if (4 * w + j < 35) r[8 * j +: 3] = tb_prio[4 * w + j];
    return r;
  endfunction
  // request held through the edge at which ready is seen high
  task automatic op(input logic p, input logic w, input logic [7:0] a, input logic [1:0] sz,
                    input logic [31:0] d, input logic f, input logic [31:0] r, input int stall);
    int n;
    n = 0;
    @(posedge clk) #1;
    if (stall > 0) ce = 1'b0;
    acc = '{1'b1, w, p, sz, a, d};
    if (stall > 0)
    begin
      repeat (stall) begin @(posedge clk) #1; `CHK(rdy, 1'b0) end
      ce = 1'b1;
    end
    while (n < 20 && rdy !== 1'b1) begin @(posedge clk) #1; n++; end
    `CHK(rdy, 1'b1)
    if (rdy !== 1'b1) timeout;
    @(posedge clk) #1;
    `CHK(flt, f)
    if (!w && !f) `CHK(rd, r)
    acc.valid = 1'b0;
  endtask
  initial begin
    logic [31:0] d;
    logic [34:0] left;
    int n, b, e;
    void'($urandom(62));
    repeat (6) @(posedge clk);
    #1 rst_n = 1;
    for (int k = 0; k < 8; k++) begin pend = k[2];
      op(k[0], 1'b1, k[1] ? 8'h14 : 8'h40, 2'($urandom_range(2, 0)), $urandom,
         !k[0] && !(k[2] && k[1]), '0, k[2] ? 2 : 0); end
    op(1'b0, 1'b0, 8'h00, 2'h2, '0, 1'b1, '0, 0);
    op(1'b1, 1'b1, 8'h18, 2'h2, 32'hFFFFFFFF, 1'b0, '0, 0);
    op(1'b1, 1'b1, 8'h1C, 2'h2, 32'h7, 1'b0, '0, 0);
    op(1'b1, 1'b1, 8'h00, 2'h2, 32'hFFFFFFFF, 1'b0, '0, 0);
    op(1'b1, 1'b1, 8'h04, 2'h2, 32'h7, 1'b0, '0, 0);
    for (int w = 0; w < 9; w++) begin d = $urandom;
      op(1'b1, 1'b1, 8'(8'h40 + 4 * w), 2'h2, d, 1'b0, '0, 0);
      for (int j = 0; j < 4; j++) if (4 * w + j < 35) tb_prio[4 * w + j] = d[8 * j +: 3]; end
    tb_prio[5] = 3'($urandom_range(7, 0));
    op(1'b1, 1'b1, 8'h45, 2'h0, 32'(tb_prio[5]) << 8, 1'b0, '0, 0);
    d = $urandom;
    tb_prio[6] = d[18:16];
    tb_prio[7] = d[26:24];
    op(1'b1, 1'b1, 8'h46, 2'h1, d, 1'b0, '0, 0);
    op(1'b1, 1'b0, 8'h44, 2'h2, '0, 1'b0, prio_word(1), 0);
    op(1'b1, 1'b0, 8'h60, 2'h2, '0, 1'b0, prio_word(8), 0);
    op(1'b1, 1'b0, 8'h04, 2'h2, '0, 1'b0, 32'h7, 0);
    op(1'b1, 1'b0, 8'h14, 2'h2, '0, 1'b0, '0, 0);
    $display("access test done");
    irq = 35'($urandom) | 35'h1;
    left = irq;
    for (e = 0; e < 40 && left != '0; e++) begin
      b = best(left);
      n = 0;
      while (n < 60 && busy !== 1'b1) begin @(posedge clk) #1; n++; end
      if (busy !== 1'b1) timeout;
      n = 0;
      while (n < 20 && hs !== 1'b1) begin @(posedge clk) #1; n++; end
      `CHK(n, e == 0 ? 12 : 6)
      `CHK(vec, b[5:0])
      `CHK(nest, 1'b1)
      left[b] = 1'b0;
    end
    repeat (6) @(posedge clk);
    #1;
    `CHK(nest, 1'b0)
    op(1'b1, 1'b0, 8'h20, 2'h2, '0, 1'b0, '0, 0);
    $display("entry test done");
    report_and_stop;
  end
endmodule // tb_nvic_core
`default_nettype wire
